// File: phy_diag_regs.svh
// Offsets, field positions, reset values and codes of the PHY diagnostic bank
`ifndef PHY_DIAG_REGS_SVH
`define PHY_DIAG_REGS_SVH
// Register indices, byte address is four times the index
`define IDX_P1_DIAG 6'h00
`define IDX_P1_CTRL 6'h02
`define IDX_P2_DIAG 6'h04
`define IDX_P1_ALIAS 6'h10
`define IDX_P2_ALIAS 6'h11
`define IDX_IRQ_STAT 6'h12
`define IDX_IRQ_MASK 6'h13
// Diagnostic register fields
`define DIAG_EN_BIT 15
`define DIAG_RES_LSB 13
`define DIAG_SHORT_BIT 12
`define DIAG_CNT_W 9
// PHY bank register zero alias fields
`define ALIAS_SHORT_BIT 15
`define ALIAS_RES_LSB 13
`define ALIAS_EN_BIT 12
`define ALIAS_FORCE_BIT 11
`define ALIAS_PWR_BIT 10
`define ALIAS_LB_BIT 9
// Special control fields
`define CTRL_POL_BIT 5
`define CTRL_MDIX_BIT 4
`define CTRL_FORCE_BIT 3
`define CTRL_PWR_BIT 2
`define CTRL_LB_BIT 1
// Reset values
`define RST_FORCE 1'b0
`define RST_PWR 1'b1
`define RST_LB 1'b0
`define RST_RESULT 2'h0
`define RST_SHORT 1'b0
`define RST_COUNT 9'h000
// Interrupt status bits
`define IRQ_P1_DONE 0
`define IRQ_P2_DONE 1
`define IRQ_BITS 2
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: phy_diag_pkg.sv
// Types shared by the PHY diagnostic register bank
`include "phy_diag_regs.svh"
package phy_diag_pkg;
  typedef enum logic [1:0] {
    CABLE_NORMAL = 2'h0,
    CABLE_OPEN = 2'h1,
    CABLE_SHORT = 2'h2,
    TEST_FAILED = 2'h3
  } diag_result_t;
  typedef enum logic [0:0] {
    DIAG_IDLE = 1'b0,
    DIAG_RUN = 1'b1
  } diag_state_t;
  // Outcome handed back by the analog measurement
  typedef struct packed {
    logic done;
    diag_result_t result;
    logic near_short_flag;
    logic [`DIAG_CNT_W-1:0] fault_count;
  } diag_report_t;
  // What software sees of one port's diagnostic
  typedef struct packed {
    logic enable;
    diag_result_t result;
    logic near_short_flag;
    logic [`DIAG_CNT_W-1:0] fault_count;
  } diag_view_t;
  typedef struct packed {
    logic force_link;
    logic power_save_off;
    logic near_loopback;
  } line_ctrl_t;
  typedef struct packed {
    logic polarity_reversed;
    logic crossover_state;
  } line_status_t;
endpackage : phy_diag_pkg

// File: cable_diag_port.sv
// Per-port cable diagnostic sequencer and result holder
`timescale 1ns/1ps
`default_nettype none
module cable_diag_port
  import phy_diag_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Software launch request
  input wire logic start_req,
  // Analog measurement side
  input wire diag_report_t report,
  output var logic start_pulse,
  // Register view and completion event
  output var diag_view_t view,
  output var logic done_pulse
);
  typedef struct packed {
    diag_state_t state;
    diag_result_t result;
    logic near_short_flag;
    logic [`DIAG_CNT_W-1:0] fault_count;
    logic start_pulse;
    logic done_pulse;
  } port_state_t;
  port_state_t cur;
  port_state_t next_cur;

  // Launch and completion; a launch while running is ignored
  always_comb begin
    next_cur = cur;
    next_cur.start_pulse = 1'b0;
    next_cur.done_pulse = 1'b0;
    unique case (cur.state)
      DIAG_IDLE: begin
        if (start_req) begin
          next_cur.state = DIAG_RUN;
          next_cur.start_pulse = 1'b1;
        end
      end
      DIAG_RUN: begin
        if (report.done) begin
          next_cur.state = DIAG_IDLE;
          next_cur.result = report.result;
          next_cur.near_short_flag = report.near_short_flag;
          next_cur.fault_count = report.fault_count;
          next_cur.done_pulse = 1'b1;
        end
      end
    endcase
  end

  // Results are only touched on completion, so they hold between tests
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur.state <= DIAG_IDLE;
      cur.result <= diag_result_t'(`RST_RESULT);
      cur.near_short_flag <= `RST_SHORT;
      cur.fault_count <= `RST_COUNT;
      cur.start_pulse <= 1'b0;
      cur.done_pulse <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign view = '{enable: (cur.state == DIAG_RUN), result: cur.result,
                  near_short_flag: cur.near_short_flag, fault_count: cur.fault_count};
  assign start_pulse = cur.start_pulse;
  assign done_pulse = cur.done_pulse;
endmodule : cable_diag_port
`default_nettype wire

// File: event_irq.sv
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module event_irq #(
  parameter int N = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Events and software access
  input wire logic [N-1:0] evt,
  input wire logic stat_rd,
  input wire logic mask_we,
  input wire logic [N-1:0] mask_wdata,
  // State and interrupt
  output var logic [N-1:0] status,
  output var logic [N-1:0] mask,
  output var logic irq
);
  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic irq;
  } irq_state_t;
  irq_state_t cur;
  irq_state_t next_cur;

  // A read clears, but an event in the same cycle survives it
  always_comb begin
    next_cur = cur;
    next_cur.status = (stat_rd ? '0 : cur.status) | evt;
    if (mask_we) begin
      next_cur.mask = mask_wdata;
    end
    next_cur.irq = |(next_cur.status & next_cur.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign status = cur.status;
  assign mask = cur.mask;
  assign irq = cur.irq;
endmodule : event_irq
`default_nettype wire

// File: phy_cable_diag_ctrl_regs.sv
// PHY cable diagnostic and special control registers behind AXI4-Lite
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module phy_cable_diag_ctrl_regs
  import phy_diag_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output var logic s_axil_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output var logic s_axil_wready,
  // AXI4-Lite write response
  output var logic [1:0] s_axil_bresp,
  output var logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output var logic s_axil_arready,
  // AXI4-Lite read data
  output var logic [31:0] s_axil_rdata,
  output var logic [1:0] s_axil_rresp,
  output var logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Port 1 analog diagnostic
  output var logic p1_diag_start,
  input wire diag_report_t p1_report,
  // Port 2 analog diagnostic
  output var logic p2_diag_start,
  input wire diag_report_t p2_report,
  // Port 1 line status and control
  input wire line_status_t p1_line_status,
  output var line_ctrl_t p1_line_ctrl,
  // Interrupt
  output var logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic have_aw;
    logic [5:0] aw_idx;
    logic have_w;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    line_ctrl_t ctrl;
  } bank_state_t;
  bank_state_t cur;
  bank_state_t next_cur;

  diag_view_t p1_view;
  diag_view_t p2_view;
  logic p1_done;
  logic p2_done;
  logic [`IRQ_BITS-1:0] irq_status;
  logic [`IRQ_BITS-1:0] irq_mask;
  logic wr_fire;
  logic rd_fire;
  logic [5:0] ar_idx;
  logic [15:0] merged;
  logic p1_start_req;
  logic p2_start_req;
  logic stat_rd;
  logic mask_we;

  ////////////////////////////////////////////////////////////////////////////
  // Register word layouts

  // Diagnostic register view
  function automatic logic [15:0] diag_word(input diag_view_t v);
    logic [15:0] w;
    w = 16'h0000;
    w[`DIAG_EN_BIT] = v.enable;
    w[`DIAG_RES_LSB +: 2] = v.result;
    w[`DIAG_SHORT_BIT] = v.near_short_flag;
    w[`DIAG_CNT_W-1:0] = v.fault_count;
    return w;
  endfunction : diag_word

  // Same storage seen through PHY register zero
  function automatic logic [15:0] alias_word(input diag_view_t v, input line_ctrl_t c,
                                             input logic has_ctrl);
    logic [15:0] w;
    w = 16'h0000;
    w[`ALIAS_EN_BIT] = v.enable;
    w[`ALIAS_RES_LSB +: 2] = v.result;
    w[`ALIAS_SHORT_BIT] = v.near_short_flag;
    w[`DIAG_CNT_W-1:0] = v.fault_count;
    if (has_ctrl) begin
      w[`ALIAS_FORCE_BIT] = c.force_link;
      w[`ALIAS_PWR_BIT] = c.power_save_off;
      w[`ALIAS_LB_BIT] = c.near_loopback;
    end
    return w;
  endfunction : alias_word

  // Special control view; bit 0 is held as zero
  function automatic logic [15:0] ctrl_word(input line_ctrl_t c, input line_status_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[`CTRL_POL_BIT] = s.polarity_reversed;
    w[`CTRL_MDIX_BIT] = s.crossover_state;
    w[`CTRL_FORCE_BIT] = c.force_link;
    w[`CTRL_PWR_BIT] = c.power_save_off;
    w[`CTRL_LB_BIT] = c.near_loopback;
    return w;
  endfunction : ctrl_word

  // Byte-lane merge of a write into an old value
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] nw,
                                             input logic [1:0] strb);
    logic [15:0] w;
    w = old;
    if (strb[0]) begin
      w[7:0] = nw[7:0];
    end
    if (strb[1]) begin
      w[15:8] = nw[15:8];
    end
    return w;
  endfunction : lane_merge

  // Known indices
  function automatic logic mapped(input logic [5:0] idx);
    return (idx == `IDX_P1_DIAG) || (idx == `IDX_P1_CTRL) || (idx == `IDX_P2_DIAG) ||
           (idx == `IDX_P1_ALIAS) || (idx == `IDX_P2_ALIAS) ||
           (idx == `IDX_IRQ_STAT) || (idx == `IDX_IRQ_MASK);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  // A write fires once both address and data are held and no response waits
  always_comb begin
    wr_fire = cur.have_aw && cur.have_w && !cur.bvalid;
    rd_fire = s_axil_arvalid && cur.arready;
    ar_idx = s_axil_araddr[7:2];
    // Control word as a lane-merged write would leave it
    merged = lane_merge(ctrl_word(cur.ctrl, p1_line_status), cur.wdata, cur.wstrb);
    p1_start_req = 1'b0;
    p2_start_req = 1'b0;
    mask_we = 1'b0;
    if (wr_fire) begin
      unique case (cur.aw_idx)
        `IDX_P1_DIAG: p1_start_req = cur.wstrb[1] && cur.wdata[`DIAG_EN_BIT];
        `IDX_P2_DIAG: p2_start_req = cur.wstrb[1] && cur.wdata[`DIAG_EN_BIT];
        `IDX_P1_ALIAS: p1_start_req = cur.wstrb[1] && cur.wdata[`ALIAS_EN_BIT];
        `IDX_P2_ALIAS: p2_start_req = cur.wstrb[1] && cur.wdata[`ALIAS_EN_BIT];
        `IDX_IRQ_MASK: mask_we = cur.wstrb[0];
        default: mask_we = 1'b0;
      endcase
    end
    // Reading the status word clears it in the same edge that captures it
    stat_rd = rd_fire && (ar_idx == `IDX_IRQ_STAT);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus and control state
  always_comb begin
    next_cur = cur;
    // Write address channel
    if (s_axil_awvalid && cur.awready) begin
      next_cur.have_aw = 1'b1;
      next_cur.aw_idx = s_axil_awaddr[7:2];
    end
    // Write data channel, upper lanes carry nothing
    if (s_axil_wvalid && cur.wready) begin
      next_cur.have_w = 1'b1;
      next_cur.wdata = s_axil_wdata[15:0];
      next_cur.wstrb = s_axil_wstrb[1:0];
    end
    // Commit and respond
    if (wr_fire) begin
      next_cur.have_aw = 1'b0;
      next_cur.have_w = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = mapped(cur.aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
      if (cur.aw_idx == `IDX_P1_CTRL) begin
        next_cur.ctrl.force_link = merged[`CTRL_FORCE_BIT];
        next_cur.ctrl.power_save_off = merged[`CTRL_PWR_BIT];
        next_cur.ctrl.near_loopback = merged[`CTRL_LB_BIT];
      end
      if ((cur.aw_idx == `IDX_P1_ALIAS) && cur.wstrb[1]) begin
        next_cur.ctrl.force_link = cur.wdata[`ALIAS_FORCE_BIT];
        next_cur.ctrl.power_save_off = cur.wdata[`ALIAS_PWR_BIT];
        next_cur.ctrl.near_loopback = cur.wdata[`ALIAS_LB_BIT];
      end
    end
    if (cur.bvalid && s_axil_bready) begin
      next_cur.bvalid = 1'b0;
    end
    // Hold off new address or data while a response is pending
    next_cur.awready = !next_cur.have_aw && !next_cur.bvalid;
    next_cur.wready = !next_cur.have_w && !next_cur.bvalid;
    // Read channel: one outstanding read
    if (rd_fire) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
      next_cur.rdata = 32'h0000_0000;
      unique case (ar_idx)
        `IDX_P1_DIAG: next_cur.rdata[15:0] = diag_word(p1_view);
        `IDX_P1_CTRL: next_cur.rdata[15:0] = ctrl_word(cur.ctrl, p1_line_status);
        `IDX_P2_DIAG: next_cur.rdata[15:0] = diag_word(p2_view);
        `IDX_P1_ALIAS: next_cur.rdata[15:0] = alias_word(p1_view, cur.ctrl, 1'b1);
        `IDX_P2_ALIAS: next_cur.rdata[15:0] = alias_word(p2_view, cur.ctrl, 1'b0);
        `IDX_IRQ_STAT: next_cur.rdata[`IRQ_BITS-1:0] = irq_status;
        `IDX_IRQ_MASK: next_cur.rdata[`IRQ_BITS-1:0] = irq_mask;
        default: next_cur.rdata = 32'h0000_0000;
      endcase
    end
    if (cur.rvalid && s_axil_rready) begin
      next_cur.rvalid = 1'b0;
    end
    next_cur.arready = !next_cur.rvalid;
  end

  // Register the whole bank state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
      cur.awready <= 1'b0;
      cur.wready <= 1'b0;
      cur.arready <= 1'b0;
      cur.ctrl.force_link <= `RST_FORCE;
      cur.ctrl.power_save_off <= `RST_PWR;
      cur.ctrl.near_loopback <= `RST_LB;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port diagnostic and interrupt

  // One storage per port, shared by both register views
  cable_diag_port u_p1_diag (
    .aclk(aclk),
    .aresetn(aresetn),
    .start_req(p1_start_req),
    .report(p1_report),
    .start_pulse(p1_diag_start),
    .view(p1_view),
    .done_pulse(p1_done)
  );

  cable_diag_port u_p2_diag (
    .aclk(aclk),
    .aresetn(aresetn),
    .start_req(p2_start_req),
    .report(p2_report),
    .start_pulse(p2_diag_start),
    .view(p2_view),
    .done_pulse(p2_done)
  );

  // Completion of either test raises a sticky event
  event_irq #(
    .N(`IRQ_BITS)
  ) u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .evt({p2_done, p1_done}),
    .stat_rd(stat_rd),
    .mask_we(mask_we),
    .mask_wdata(cur.wdata[`IRQ_BITS-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign s_axil_awready = cur.awready;
  assign s_axil_wready = cur.wready;
  assign s_axil_bvalid = cur.bvalid;
  assign s_axil_bresp = cur.bresp;
  assign s_axil_arready = cur.arready;
  assign s_axil_rvalid = cur.rvalid;
  assign s_axil_rresp = cur.rresp;
  assign s_axil_rdata = cur.rdata;
  assign p1_line_ctrl = cur.ctrl;
endmodule : phy_cable_diag_ctrl_regs
`default_nettype wire

// File: phy_cable_diag_ctrl_regs_asserts.sv
// Port-level assertions for the PHY diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
module phy_cable_diag_ctrl_regs_asserts
  import phy_diag_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic s_axil_bvalid,
  input wire logic [ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Line side
  input wire logic p1_diag_start,
  input wire logic p2_diag_start,
  input wire line_ctrl_t p1_line_ctrl
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [ADDR_W-1:0] rd_addr;

  // Remember the address of the read in flight
  always_ff @(posedge aclk) begin
    if (s_axil_arvalid && s_axil_arready) begin
      rd_addr <= s_axil_araddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Launch pulses only follow a committed write, and last one cycle
  AST_START_P1: assert property (p1_diag_start |-> s_axil_bvalid ##1 !p1_diag_start)
    else $error("port 1 start pulse not tied to a write");
  AST_START_P2: assert property (p2_diag_start |-> s_axil_bvalid ##1 !p2_diag_start)
    else $error("port 2 start pulse not tied to a write");
  AST_LINE_RESET: assert property ($rose(aresetn) |-> p1_line_ctrl == 3'b010)
    else $error("line control reset value wrong");
  AST_RD_HIGH: assert property (s_axil_rvalid |-> s_axil_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  AST_DIAG_RSV: assert property (s_axil_rvalid && (rd_addr == 8'h00 || rd_addr == 8'h10)
    |-> s_axil_rdata[11:9] == 3'h0)
    else $error("diagnostic reserved bits not zero");
  AST_CTRL_RSV: assert property (s_axil_rvalid && rd_addr == 8'h08
    |-> s_axil_rdata[15:6] == 10'h000 && !s_axil_rdata[0])
    else $error("control reserved bits not zero");
  // Control readback tracks the line control outputs
  AST_CTRL_LINE: assert property ($rose(s_axil_rvalid) && rd_addr == 8'h08
    |-> s_axil_rdata[3:1] == $past(p1_line_ctrl))
    else $error("control readback differs from line control");
  AST_RVALID_HOLD: assert property (s_axil_rvalid && !s_axil_rready
    |=> s_axil_rvalid && $stable(s_axil_rdata))
    else $error("read data dropped before accepted");
  AST_WR_TIMING: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid
    && s_axil_wready |-> ##2 s_axil_bvalid)
    else $error("write response late");
endmodule : phy_cable_diag_ctrl_regs_asserts

bind phy_cable_diag_ctrl_regs phy_cable_diag_ctrl_regs_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .aclk, .aresetn, .s_axil_awvalid, .s_axil_awready, .s_axil_wvalid, .s_axil_wready,
  .s_axil_bvalid, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
  .s_axil_rvalid, .s_axil_rready, .p1_diag_start, .p2_diag_start, .p1_line_ctrl
);
`default_nettype wire

// File: test_phy_cable_diag_ctrl_regs.sv
// Self-checking bench for the PHY diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
module test_phy_cable_diag_ctrl_regs;
  import phy_diag_pkg::*;
  logic aclk, aresetn;
  logic [7:0] s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata, rd, prev1, prev2;
  logic [3:0] s_axil_wstrb;
  logic [1:0] s_axil_bresp, s_axil_rresp, rs;
  logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid;
  logic s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
  logic p1_diag_start, p2_diag_start, irq;
  diag_report_t p1_report, p2_report;
  line_status_t p1_line_status;
  line_ctrl_t p1_line_ctrl;
  int err_count, checks_done, cycles, p1_starts, p2_starts;

  phy_cable_diag_ctrl_regs uut (
    .aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata,
    .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
    .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
    .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .p1_diag_start, .p1_report,
    .p2_diag_start, .p2_report, .p1_line_status, .p1_line_ctrl, .irq
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Launch pulses are counted in the cycle in which they stand
  always @(posedge aclk) begin
    cycles++;
    p1_starts += (p1_diag_start === 1'b1);
    p2_starts += (p2_diag_start === 1'b1);
    if (cycles == 6000) begin
      err_count++;
      wrap_up();
    end
  end

  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////////
  // Bus master: hold each channel until its own ready
  task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_p, w_p;
    @(posedge aclk);
    aw_p = 1'b1;
    w_p = 1'b1;
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_wstrb <= s;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && s_axil_awready === 1'b1) begin
        s_axil_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && s_axil_wready === 1'b1) begin
        s_axil_wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    do @(posedge aclk); while (s_axil_bvalid !== 1'b1);
    rs = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask : axi_write

  task axi_read(input logic [7:0] a);
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do @(posedge aclk); while (s_axil_arready !== 1'b1);
    s_axil_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axil_rvalid !== 1'b1);
    rd = s_axil_rdata;
    rs = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask : axi_read

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    check(rd, exp);
    check({30'h0, rs}, 32'h0);
  endtask : rd_chk

  // Analog side reports completion for one cycle
  task pulse_done(input int p, input diag_report_t r);
    @(posedge aclk);
    if (p == 1) p2_report <= r;
    else p1_report <= r;
    @(posedge aclk);
    p1_report.done <= 1'b0;
    p2_report.done <= 1'b0;
  endtask : pulse_done

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task test_reset;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h08, 32'h4);
    rd_chk(8'h10, 32'h0);
    check({29'h0, p1_line_ctrl}, 32'h2);
    $display("test reset finished");
  endtask : test_reset

  // Every result code on both ports, with alias, hold and interrupt
  task test_diag;
    diag_report_t rep;
    logic [31:0] ex;
    logic [7:0] base;
    axi_write(8'h4C, 32'h3, 4'h1);
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 4; r++) begin
        base = p[0] ? 8'h10 : 8'h00;
        axi_write(base, 32'h8000, 4'h3);
        rd_chk(base, {17'h1, (p[0] ? prev2[14:0] : prev1[14:0])});
        rep = {1'b1, r[1:0], r[0], 9'h1F0 + 9'(r)};
        pulse_done(p, rep);
        ex = {17'h0, r[1:0], r[0], 3'h0, 9'h1F0 + 9'(r)};
        rd_chk(base, ex);
        rd_chk(8'h40 + 8'(4 * p), {16'h0, r[0], r[1:0], 1'b0, (p[0] ? 3'h0 : 3'h2),
          9'h1F0 + 9'(r)});
        check({31'h0, irq}, 32'h1);
        rd_chk(8'h48, 32'h1 << p);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        if (p[0]) prev2 = ex;
        else prev1 = ex;
      end
    end
    rep = '1;
    pulse_done(0, rep);
    rd_chk(8'h00, prev1);
    axi_write(8'h40, 32'h1400, 4'h2);
    check({29'h0, p1_line_ctrl}, 32'h2);
    rd_chk(8'h00, prev1 | 32'h8000);
    pulse_done(0, 13'h1000);
    rd_chk(8'h00, 32'h0);
    axi_write(8'h4C, 32'h0, 4'h1);
    axi_write(8'h10, 32'h8000, 4'h3);
    pulse_done(1, 13'h1000);
    rd_chk(8'h10, 32'h0);
    check({31'h0, irq}, 32'h0);
    rd_chk(8'h48, 32'h3);
    rd_chk(8'h48, 32'h0);
    check(p1_starts, 32'd5);
    check(p2_starts, 32'd5);
    $display("test diag finished");
  endtask : test_diag

  task test_ctrl;
    p1_line_status <= 2'b10;
    rd_chk(8'h08, 32'h24);
    axi_write(8'h08, 32'hFFFF_FFFF, 4'hF);
    check({30'h0, rs}, 32'h0);
    rd_chk(8'h08, 32'h2E);
    check({29'h0, p1_line_ctrl}, 32'h7);
    rd_chk(8'h40, 32'h0E00);
    axi_write(8'h08, 32'h0, 4'h3);
    p1_line_status <= 2'b01;
    rd_chk(8'h08, 32'h10);
    check({29'h0, p1_line_ctrl}, 32'h0);
    $display("test ctrl finished");
  endtask : test_ctrl

  // Unmapped word refuses both directions
  task test_unmapped;
    axi_write(8'h3C, 32'hFFFF, 4'h3);
    check({30'h0, rs}, 32'h2);
    axi_read(8'h3C);
    check(rd, 32'h0);
    check({30'h0, rs}, 32'h2);
    $display("test unmapped finished");
  endtask : test_unmapped

  // Main sequence
  initial begin
    {aresetn, s_axil_awaddr, s_axil_araddr, s_axil_wdata, s_axil_wstrb} = '0;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = '0;
    {p1_report, p2_report, p1_line_status, prev1, prev2} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_diag();
    test_ctrl();
    test_unmapped();
    wrap_up();
  end
endmodule : test_phy_cable_diag_ctrl_regs
`default_nettype wire
